// >>> rtl/light_proximity_sensor_regs.sv
// Operation
// - Twelve byte-wide host registers: config, interrupt, thresholds, results, test.
// - Offsets 0x3 to 0x7 hold near and light thresholds; near events use only 0x4.
// - Offsets 0x8 to 0xA hold latest near and light results, readable.
// - Offset 0x00 is reserved, read-only, returns no meaningful content.
// - Near enable clear stops sensing; set runs it, first result after 0.54ms.
// - Three-bit sleep code picks idle between emitter pulses, 0 to 800ms.
// - Emitter drive bit selects 110mA when clear, 220mA when set.
// - Light enable clear stops sensing; set gives new result every 100ms.
// - Light range bit picks low-lux range when clear, high-lux when set.
// - Spectrum bit makes light result visible when clear, infrared when set.
// - Near event flag sets on event, holds until host writes 0.
// - Light event flag sets on event, holds until host writes 0.
// - Near persistence code needs 1, 4, 8 or 16 tripping conversions.
// - Light persistence code needs 1, 4, 8 or 16 out-of-window conversions.
// - Combine bit clear: interrupt pin low when either flag is set.
// - Combine bit set: interrupt pin low only while both flags set.
// - Test registers at zero mean normal operation; host writes only 0x00.
// - Twelve-bit light result split over 0x9 and 0xA after conversion.
// - Near conversions repeat, spaced by the selected sleep interval.
`timescale 1ns/1ns
`default_nettype none

module light_proximity_sensor_regs
  import sensor_pkg::*;
#(
  parameter int NEAR_CONV_CYCLES = NEAR_CONV_CYC,
  parameter int LIGHT_PERIOD_CYCLES = LIGHT_PERIOD_CYC,
  parameter int SLEEP_UNIT_CYCLES = SLEEP_UNIT_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Register port from the serial bus slave engine
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Converter front end
  input wire logic [7:0] NEAR_SAMPLE_I,
  input wire logic [11:0] LIGHT_SAMPLE_I,
  output logic EMITTER_DRIVER_OUT_O,
  output logic EMITTER_HIGH_O,
  output logic LIGHT_ACTIVE_O,
  output logic LIGHT_RANGE_O,
  output logic SPECTRUM_O,
  output logic TEST_MODE_O,
  // Open-drain interrupt pin
  output logic INT_O,
  output logic INT_OE_N_O
);

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(NEAR_CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] LIGHT_LAST = CNT_W'(LIGHT_PERIOD_CYCLES - 1);

  sensor_state_t st;
  sensor_state_t next_st;
  reg_req_t req;
  logic [11:0] light_low;
  logic [11:0] light_high;
  logic near_trip;
  logic light_trip;
  logic int_active;

  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I,
                 wdata: REG_WDATA_I};

  // Number of consecutive trips needed for each persistence code.
  function automatic logic [4:0] persist_need(input logic [1:0] code);
    case (code)
      2'b00: persist_need = 5'd1;
      2'b01: persist_need = 5'd4;
      2'b10: persist_need = 5'd8;
      default: persist_need = 5'd16;
    endcase
  endfunction

  // Sleep length in cycles for a sleep code; zero means back to back.
  function automatic logic [CNT_W-1:0] sleep_cycles(input logic [2:0] code);
    sleep_cycles = CNT_W'(int'(SLEEP_MULT[code]) * SLEEP_UNIT_CYCLES);
  endfunction

  function automatic logic [7:0] read_mux(input sensor_state_t s,
                                          input logic [7:0] addr);
    case (addr)
      ADDR_CONFIG: read_mux = s.cfg;
      ADDR_INT_CTRL: read_mux = {s.near_flag, s.near_prst, 1'b0,
                                 s.light_flag, s.light_prst, s.combine};
      ADDR_NEAR_LO: read_mux = s.near_lo;
      ADDR_NEAR_HI: read_mux = s.near_hi;
      ADDR_LIGHT_TH1: read_mux = s.light_th1;
      ADDR_LIGHT_TH2: read_mux = s.light_th2;
      ADDR_LIGHT_TH3: read_mux = s.light_th3;
      ADDR_NEAR_RESULT: read_mux = s.near_result;
      ADDR_LIGHT_RES_LO: read_mux = s.light_result[7:0];
      ADDR_LIGHT_RES_HI: read_mux = {4'h0, s.light_result[11:8]};
      ADDR_TEST_A: read_mux = s.test_a;
      ADDR_TEST_B: read_mux = s.test_b;
      // The reserved location and every unmapped offset read as zero.
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Light window is low threshold below, high threshold above.
  assign light_low = {st.light_th2[3:0], st.light_th1};
  assign light_high = {st.light_th3, st.light_th2[7:4]};
  assign near_trip = NEAR_SAMPLE_I > st.near_hi;
  assign light_trip = (LIGHT_SAMPLE_I < light_low) ||
                      (LIGHT_SAMPLE_I > light_high);

  always_comb begin
    next_st = st;
    next_st.near_done = 1'b0;
    next_st.light_done = 1'b0;
    next_st.rvalid = 1'b0;

    if (req.wr) begin
      case (req.addr)
        ADDR_CONFIG: next_st.cfg = req.wdata;
        ADDR_INT_CTRL: begin
          // Flags only clear on a written zero; a written one is ignored.
          next_st.near_flag = st.near_flag & req.wdata[INT_NEAR_FLAG];
          next_st.light_flag = st.light_flag & req.wdata[INT_LIGHT_FLAG];
          next_st.near_prst = req.wdata[INT_NEAR_PRST_LSB +: 2];
          next_st.light_prst = req.wdata[INT_LIGHT_PRST_LSB +: 2];
          next_st.combine = req.wdata[INT_COMBINE];
        end
        ADDR_NEAR_LO: next_st.near_lo = req.wdata;
        ADDR_NEAR_HI: next_st.near_hi = req.wdata;
        ADDR_LIGHT_TH1: next_st.light_th1 = req.wdata;
        ADDR_LIGHT_TH2: next_st.light_th2 = req.wdata;
        ADDR_LIGHT_TH3: next_st.light_th3 = req.wdata;
        ADDR_TEST_A: next_st.test_a = req.wdata;
        ADDR_TEST_B: next_st.test_b = req.wdata;
        default: next_st.cfg = st.cfg;
      endcase
    end

    if (req.rd) begin
      next_st.rdata = read_mux(st, req.addr);
      next_st.rvalid = 1'b1;
    end

    // Proximity sequencer: convert, capture, sleep, repeat.
    case (st.near_phase)
      NEAR_IDLE: begin
        if (st.cfg[CFG_NEAR_EN]) begin
          next_st.near_phase = NEAR_CONVERT;
          next_st.near_cnt = CONV_LAST;
        end
      end
      NEAR_CONVERT: begin
        if (!st.cfg[CFG_NEAR_EN]) begin
          next_st.near_phase = NEAR_IDLE;
        end else if (st.near_cnt == '0) begin
          next_st.near_result = NEAR_SAMPLE_I;
          next_st.near_done = 1'b1;
          if (sleep_cycles(st.cfg[CFG_SLEEP_LSB +: 3]) == '0) begin
            next_st.near_cnt = CONV_LAST;
          end else begin
            next_st.near_phase = NEAR_SLEEP;
            next_st.near_cnt = sleep_cycles(st.cfg[CFG_SLEEP_LSB +: 3]) -
                               CNT_W'(1);
          end
        end else begin
          next_st.near_cnt = st.near_cnt - CNT_W'(1);
        end
      end
      NEAR_SLEEP: begin
        if (!st.cfg[CFG_NEAR_EN]) begin
          next_st.near_phase = NEAR_IDLE;
        end else if (st.near_cnt == '0) begin
          next_st.near_phase = NEAR_CONVERT;
          next_st.near_cnt = CONV_LAST;
        end else begin
          next_st.near_cnt = st.near_cnt - CNT_W'(1);
        end
      end
      default: next_st.near_phase = NEAR_IDLE;
    endcase

    // Light runs a fixed conversion period while enabled.
    if (!st.cfg[CFG_LIGHT_EN]) begin
      next_st.light_cnt = '0;
    end else if (st.light_cnt == LIGHT_LAST) begin
      next_st.light_cnt = '0;
      next_st.light_result = LIGHT_SAMPLE_I;
      next_st.light_done = 1'b1;
    end else begin
      next_st.light_cnt = st.light_cnt + CNT_W'(1);
    end

    // Persistence runs after the host write so that an event wins over a
    // clear arriving in the same cycle.
    if (next_st.near_done) begin
      if (!near_trip) begin
        next_st.near_hits = 5'd0;
      end else if (st.near_hits + 5'd1 >= persist_need(st.near_prst)) begin
        next_st.near_hits = 5'd0;
        next_st.near_flag = 1'b1;
      end else begin
        next_st.near_hits = st.near_hits + 5'd1;
      end
    end
    if (next_st.light_done) begin
      if (!light_trip) begin
        next_st.light_hits = 5'd0;
      end else if (st.light_hits + 5'd1 >= persist_need(st.light_prst)) begin
        next_st.light_hits = 5'd0;
        next_st.light_flag = 1'b1;
      end else begin
        next_st.light_hits = st.light_hits + 5'd1;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st <= '0;
      st.cfg <= RST_CONFIG;
      st.near_lo <= RST_NEAR_LO;
      st.near_hi <= RST_NEAR_HI;
      st.light_th1 <= RST_LIGHT_TH1;
      st.light_th2 <= RST_LIGHT_TH2;
      st.light_th3 <= RST_LIGHT_TH3;
      st.test_a <= RST_TEST;
      st.test_b <= RST_TEST;
      st.near_phase <= NEAR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // The pin only ever pulls low; the pull-up makes the high level.
  assign int_active = st.combine ? (st.near_flag & st.light_flag)
                                 : (st.near_flag | st.light_flag);
  assign INT_O = 1'b0;
  assign INT_OE_N_O = ~int_active;
  assign REG_RDATA_O = st.rdata;
  assign REG_RVALID_O = st.rvalid;
  assign EMITTER_DRIVER_OUT_O = st.near_phase == NEAR_CONVERT;
  assign EMITTER_HIGH_O = st.cfg[CFG_DRIVE];
  assign LIGHT_ACTIVE_O = st.cfg[CFG_LIGHT_EN];
  assign LIGHT_RANGE_O = st.cfg[CFG_RANGE];
  assign SPECTRUM_O = st.cfg[CFG_SPECTRUM];
  // Any nonzero test byte leaves normal operation.
  assign TEST_MODE_O = |{st.test_a, st.test_b};

  // Checking helpers: independent ages of the two conversion windows.
  logic [CNT_W-1:0] conv_age;
  logic [CNT_W-1:0] light_age;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      conv_age <= '0;
      light_age <= '0;
    end else begin
      // Restart at every capture, so back-to-back windows and periods are
      // timed the same way as the first one.
      if (next_st.near_done || st.near_phase != NEAR_CONVERT) begin
        conv_age <= '0;
      end else begin
        conv_age <= conv_age + CNT_W'(1);
      end
      if (next_st.light_done || !st.cfg[CFG_LIGHT_EN]) begin
        light_age <= '0;
      end else begin
        light_age <= light_age + CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_near_flag_kept;
    st.near_flag && !(req.wr && req.addr == ADDR_INT_CTRL &&
                      !req.wdata[INT_NEAR_FLAG]);
  endsequence
  sequence s_light_flag_kept;
    st.light_flag && !(req.wr && req.addr == ADDR_INT_CTRL &&
                       !req.wdata[INT_LIGHT_FLAG]);
  endsequence
  sequence s_config_write;
    req.wr && req.addr == ADDR_CONFIG;
  endsequence
  sequence s_reserved_read;
    req.rd && req.addr == ADDR_RESERVED;
  endsequence

  a_near_flag_sticky: assert property (
    s_near_flag_kept |=> st.near_flag)
    else $error("near flag dropped without a clearing write");
  a_light_flag_sticky: assert property (
    s_light_flag_kept |=> st.light_flag)
    else $error("light flag dropped without a clearing write");
  a_int_or_mode: assert property (
    !st.combine |-> INT_OE_N_O == !(st.near_flag || st.light_flag))
    else $error("interrupt pin wrong in either-flag mode");
  a_int_and_mode: assert property (
    st.combine |-> INT_OE_N_O == !(st.near_flag && st.light_flag))
    else $error("interrupt pin wrong in both-flags mode");
  a_near_conv_time: assert property (
    $rose(st.near_done) |-> $past(conv_age) == CONV_LAST)
    else $error("near conversion length wrong");
  a_near_stop: assert property (
    !st.cfg[CFG_NEAR_EN] ##1 !st.cfg[CFG_NEAR_EN] |->
      st.near_phase == NEAR_IDLE && !EMITTER_DRIVER_OUT_O)
    else $error("near sensing did not stop");
  a_light_period: assert property (
    st.light_done |-> $past(light_age) == LIGHT_LAST)
    else $error("light result period wrong");
  a_light_capture: assert property (
    st.light_done |-> st.light_result == $past(LIGHT_SAMPLE_I))
    else $error("light result not captured");
  a_reserved_read: assert property (
    s_reserved_read |=> REG_RVALID_O && REG_RDATA_O == 8'h00)
    else $error("reserved read not answered with zero");
  a_near_single: assert property (
    st.near_prst == 2'b00 && next_st.near_done && near_trip |=>
      st.near_flag)
    else $error("single near trip did not set flag");
  a_hits_cleared: assert property (
    next_st.light_done && !light_trip |=> st.light_hits == 5'd0)
    else $error("light persistence count not cleared");
  a_near_capture: assert property (
    next_st.near_done |=> st.near_result == $past(NEAR_SAMPLE_I))
    else $error("near result not captured");
  a_light_single: assert property (
    st.light_prst == 2'b00 && next_st.light_done && light_trip |=>
      st.light_flag)
    else $error("single light trip did not set flag");
  a_drive_select: assert property (
    s_config_write |=> EMITTER_HIGH_O == $past(REG_WDATA_I[CFG_DRIVE]))
    else $error("emitter drive level not taken from config");
  a_range_select: assert property (
    s_config_write |=> LIGHT_RANGE_O == $past(REG_WDATA_I[CFG_RANGE]))
    else $error("light range not taken from config");
  a_spectrum_select: assert property (
    s_config_write |=> SPECTRUM_O == $past(REG_WDATA_I[CFG_SPECTRUM]))
    else $error("spectrum select not taken from config");
  a_read_answer: assert property (
    req.rd |=> REG_RVALID_O)
    else $error("register read not answered");

endmodule // light_proximity_sensor_regs

`default_nettype wire

// >>> rtl/sensor_pkg.sv
package sensor_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] ADDR_RESERVED = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h02;
  localparam logic [7:0] ADDR_NEAR_LO = 8'h03;
  localparam logic [7:0] ADDR_NEAR_HI = 8'h04;
  localparam logic [7:0] ADDR_LIGHT_TH1 = 8'h05;
  localparam logic [7:0] ADDR_LIGHT_TH2 = 8'h06;
  localparam logic [7:0] ADDR_LIGHT_TH3 = 8'h07;
  localparam logic [7:0] ADDR_NEAR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_LIGHT_RES_LO = 8'h09;
  localparam logic [7:0] ADDR_LIGHT_RES_HI = 8'h0A;
  localparam logic [7:0] ADDR_TEST_A = 8'h0E;
  localparam logic [7:0] ADDR_TEST_B = 8'h0F;

  // Reset values.
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_NEAR_LO = 8'h00;
  localparam logic [7:0] RST_NEAR_HI = 8'hFF;
  localparam logic [7:0] RST_LIGHT_TH1 = 8'h00;
  localparam logic [7:0] RST_LIGHT_TH2 = 8'hF0;
  localparam logic [7:0] RST_LIGHT_TH3 = 8'hFF;
  localparam logic [7:0] RST_TEST = 8'h00;

  // Field positions of the configuration register.
  localparam int CFG_NEAR_EN = 7;
  localparam int CFG_SLEEP_LSB = 4;
  localparam int CFG_DRIVE = 3;
  localparam int CFG_LIGHT_EN = 2;
  localparam int CFG_RANGE = 1;
  localparam int CFG_SPECTRUM = 0;

  // Field positions of the interrupt control and status register.
  localparam int INT_NEAR_FLAG = 7;
  localparam int INT_NEAR_PRST_LSB = 5;
  localparam int INT_LIGHT_FLAG = 3;
  localparam int INT_LIGHT_PRST_LSB = 1;
  localparam int INT_COMBINE = 0;

  // Times in microseconds and their cycle counts at the core clock.
  localparam int CLK_MHZ = 10;
  localparam int NEAR_CONV_US = 540;
  localparam int LIGHT_PERIOD_US = 100000;
  localparam int SLEEP_UNIT_US = 12500;
  localparam int NEAR_CONV_CYC = NEAR_CONV_US * CLK_MHZ;
  localparam int LIGHT_PERIOD_CYC = LIGHT_PERIOD_US * CLK_MHZ;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_US * CLK_MHZ;

  // Sleep codes 000..111 as multiples of the 12.5 ms unit.
  localparam logic [6:0] SLEEP_MULT [8] = '{
    7'd64, 7'd32, 7'd16, 7'd8, 7'd6, 7'd4, 7'd1, 7'd0};

  localparam int CNT_W = 24;

  typedef enum logic [1:0] {NEAR_IDLE, NEAR_CONVERT, NEAR_SLEEP}
    near_phase_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic near_flag;
    logic [1:0] near_prst;
    logic light_flag;
    logic [1:0] light_prst;
    logic combine;
    logic [7:0] near_lo;
    logic [7:0] near_hi;
    logic [7:0] light_th1;
    logic [7:0] light_th2;
    logic [7:0] light_th3;
    logic [7:0] near_result;
    logic [11:0] light_result;
    logic [7:0] test_a;
    logic [7:0] test_b;
    near_phase_t near_phase;
    logic [CNT_W-1:0] near_cnt;
    logic [CNT_W-1:0] light_cnt;
    logic [4:0] near_hits;
    logic [4:0] light_hits;
    logic near_done;
    logic light_done;
    logic [7:0] rdata;
    logic rvalid;
  } sensor_state_t;

endpackage

// >>> sim/light_proximity_sensor_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

module light_proximity_sensor_regs_tb;
  import sensor_pkg::*;
  localparam int NC = 20;
  localparam int LP = 50;
  localparam int SU = 10;
  localparam logic [7:0] RA [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
    8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0E, 8'h0F, 8'h0B};
  localparam logic [7:0] RV [14] = '{8'h00, RST_CONFIG, 8'h00, RST_NEAR_LO,
    RST_NEAR_HI, RST_LIGHT_TH1, RST_LIGHT_TH2, RST_LIGHT_TH3, 8'h00, 8'h00,
    8'h00, RST_TEST, RST_TEST, 8'h00};
  logic clk, rst, wr_s, rd_s, rvalid, emit, ehigh, lact, lrange, spec;
  logic tmode, int_o, int_oe_n;
  logic [7:0] addr, wdata, rdata, near_lvl, near_s;
  logic [11:0] light_lvl, light_s;
  logic [31:0] seed;
  int err_total, num_checks;

  light_proximity_sensor_regs #(.NEAR_CONV_CYCLES(NC),
    .LIGHT_PERIOD_CYCLES(LP), .SLEEP_UNIT_CYCLES(SU)) uut (
    .CLK_I(clk), .RESET_I(rst), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .NEAR_SAMPLE_I(near_s), .LIGHT_SAMPLE_I(light_s),
    .EMITTER_DRIVER_OUT_O(emit), .EMITTER_HIGH_O(ehigh),
    .LIGHT_ACTIVE_O(lact), .LIGHT_RANGE_O(lrange), .SPECTRUM_O(spec),
    .TEST_MODE_O(tmode), .INT_O(int_o), .INT_OE_N_O(int_oe_n));
  sensor_front_model front (.clk_i(clk), .emitter_i(emit),
    .light_active_i(lact), .near_level_i(near_lvl),
    .light_level_i(light_lvl), .near_sample_o(near_s),
    .light_sample_o(light_s));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic int need_of(input int k);
    return (k == 0) ? 1 : (2 << k);
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    wr_s = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_s = 1'b1;
    addr = a;
    @(negedge clk);
    rd_s = 1'b0;
    check("read valid", 16'(rvalid), 16'h0001);
    d = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    logic [7:0] d;
    rd(a, d);
    check("register", {a, d}, {a, exp});
  endtask
  // Every wait is bounded; a stuck emitter ends the run as a failure.
  task automatic wait_emit(input logic lvl, output int n);
    n = 0;
    while (emit !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 2000) begin
        err_total++;
        $display("mismatch emitter expected %b seen timeout", lvl);
        final_report();
      end
    end
  endtask

  initial begin
    int n;
    logic [7:0] v;
    seed = 32'h1210;
    err_total = 0;
    num_checks = 0;
    {wr_s, rd_s, addr, wdata} = '0;
    near_lvl = 8'h00;
    light_lvl = 12'h000;
    rst = 1'b1;
    tick(12);
    check("reset outputs", {rvalid, emit, lact, tmode, int_o, int_oe_n},
          16'h0001);
    rst = 1'b0;
    for (int i = 0; i < 14; i++) rdc(RA[i], RV[i]);
    $display("test reset values done");
    for (int i = 3; i < 8; i++) begin
      rnd(v);
      wr(8'(i), v);
      rdc(8'(i), v);
    end
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      v = v & 8'h7B;
      wr(ADDR_CONFIG, v);
      check("cfg pins", {ehigh, lrange, spec}, {v[3], v[1], v[0]});
      rdc(ADDR_CONFIG, v);
    end
    wr(ADDR_NEAR_RESULT, 8'hFF);
    rdc(ADDR_NEAR_RESULT, 8'h00);
    wr(ADDR_INT_CTRL, 8'hEF);
    rdc(ADDR_INT_CTRL, 8'h67);
    wr(ADDR_TEST_A, 8'h00);
    check("test mode", 16'(tmode), 16'h0000);
    wr(ADDR_TEST_B, 8'h00);
    check("test mode", 16'(tmode), 16'h0000);
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_INT_CTRL, 8'h00);
    wr(ADDR_NEAR_HI, 8'hFF);
    $display("test access done");
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_CONFIG, {1'b1, 3'(c), 4'h0});
      wait_emit(1'b1, n);
      wait_emit(1'b0, n);
      check("window", 16'(n), 16'(NC));
      wait_emit(1'b1, n);
      check("sleep", 16'(n), 16'(SLEEP_MULT[c] * SU));
      wr(ADDR_CONFIG, 8'h00);
      tick(2);
    end
    wr(ADDR_CONFIG, 8'hF0);
    wait_emit(1'b1, n);
    n = 0;
    for (int i = 0; i < 60; i++) begin
      tick(1);
      if (emit !== 1'b1) n++;
    end
    check("no sleep gaps", 16'(n), 16'h0000);
    wr(ADDR_CONFIG, 8'h00);
    $display("test sleep codes done");
    rnd(v);
    near_lvl = 8'h80 | v;
    wr(ADDR_NEAR_HI, 8'h40);
    wr(ADDR_INT_CTRL, 8'h20);
    wr(ADDR_CONFIG, 8'hE0);
    for (int i = 0; i < 3; i++) begin
      wait_emit(1'b1, n);
      wait_emit(1'b0, n);
    end
    check("near early", 16'(int_oe_n), 16'h0001);
    wait_emit(1'b1, n);
    wait_emit(1'b0, n);
    tick(2);
    check("near flag", 16'(int_oe_n), 16'h0000);
    rdc(ADDR_NEAR_RESULT, near_lvl);
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_INT_CTRL, 8'h00);
    check("near clear", 16'(int_oe_n), 16'h0001);
    $display("test near persistence done");
    wr(ADDR_LIGHT_TH1, 8'h00);
    wr(ADDR_LIGHT_TH2, 8'h01);
    wr(ADDR_LIGHT_TH3, 8'h80);
    for (int k = 0; k < 4; k++) begin
      rnd(v);
      light_lvl = 12'h900 + 12'(v);
      wr(ADDR_INT_CTRL, 8'(k << 1));
      wr(ADDR_CONFIG, 8'h04);
      check("light on", 16'(lact), 16'h0001);
      tick(need_of(k) * LP - 6);
      check("light early", 16'(int_oe_n), 16'h0001);
      tick(12);
      check("light flag", 16'(int_oe_n), 16'h0000);
      rdc(ADDR_LIGHT_RES_LO, light_lvl[7:0]);
      rdc(ADDR_LIGHT_RES_HI, {4'h0, light_lvl[11:8]});
      light_lvl = 12'h300;
      tick(LP);
      wr(ADDR_INT_CTRL, 8'(k << 1));
      tick(LP + 5);
      check("in window", 16'(int_oe_n), 16'h0001);
      wr(ADDR_CONFIG, 8'h00);
    end
    $display("test light persistence done");
    wr(ADDR_INT_CTRL, 8'h01);
    wr(ADDR_CONFIG, 8'hE0);
    wait_emit(1'b1, n);
    wait_emit(1'b0, n);
    tick(2);
    check("and one flag", 16'(int_oe_n), 16'h0001);
    rdc(ADDR_INT_CTRL, 8'h81);
    light_lvl = 12'hA00;
    wr(ADDR_CONFIG, 8'h04);
    tick(LP + 10);
    check("and both", 16'(int_oe_n), 16'h0000);
    rdc(ADDR_INT_CTRL, 8'h89);
    wr(ADDR_INT_CTRL, 8'h08);
    check("or one flag", 16'(int_oe_n), 16'h0000);
    rdc(ADDR_INT_CTRL, 8'h08);
    $display("test combine done");
    final_report();
  end
endmodule // light_proximity_sensor_regs_tb

`default_nettype wire

// >>> sim/sensor_front_model.sv
`timescale 1ns/1ns
`default_nettype none

module sensor_front_model (
  // Clock and control from the block
  input wire logic clk_i,
  input wire logic emitter_i,
  input wire logic light_active_i,
  // Levels chosen by the bench
  input wire logic [7:0] near_level_i,
  input wire logic [11:0] light_level_i,
  // Converter outputs
  output logic [7:0] near_sample_o,
  output logic [11:0] light_sample_o
);
  // An idle converter shows a changing pattern, so stale data cannot pass.
  initial begin
    near_sample_o = 8'h00;
    light_sample_o = 12'h000;
  end
  always @(negedge clk_i) begin
    near_sample_o <= emitter_i ? near_level_i : ~near_sample_o;
    light_sample_o <= light_active_i ? light_level_i : ~light_sample_o;
  end
endmodule // sensor_front_model

`default_nettype wire
